// ==== bench/host_port.sv ====
// Host model: pointer byte, data pairs, paired byte reads
// Assumes the core takes strobes on the rising edge
`timescale 1ns/1ps
module host_port
(
  input  wire       clock,
  input  wire [7:0] read_data,
  output reg        frame_start,
  output reg        byte_valid,
  output reg  [7:0] byte_data,
  output reg        read_byte
);
  initial
  begin
    frame_start = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    read_byte = 1'b0;
  end
  // ==================================================
  // Transfers; released data is inverted so a stale byte never looks current
  task write_reg(input [7:0] ptr, input [15:0] d);
  begin
    @(negedge clock) frame_start = 1'b1;
    @(negedge clock) frame_start = 1'b0;
    byte_valid = 1'b1;
    byte_data = ptr;
    @(negedge clock) byte_data = d[15:8];
    @(negedge clock) byte_data = d[7:0];
    @(negedge clock) byte_valid = 1'b0;
    byte_data = ~d[7:0];
  end
  endtask
  task read_reg(input [7:0] ptr, output [15:0] d);
  begin
    @(negedge clock) frame_start = 1'b1;
    @(negedge clock) frame_start = 1'b0;
    byte_valid = 1'b1;
    byte_data = ptr;
    @(negedge clock) byte_valid = 1'b0;
    byte_data = ~ptr;
    read_byte = 1'b1;
    @(negedge clock) read_byte = 1'b0;
    // Core returns the low byte first; on the alert select register that read also clears the done flag
    @(negedge clock) d[7:0] = read_data;
    read_byte = 1'b1;
    @(negedge clock) read_byte = 1'b0;
    @(negedge clock) d[15:8] = read_data;
  end
  endtask
endmodule

// ==== bench/power_monitor_checker_asserts.sv ====
// Port checker for the monitor core
// Assumes bind onto power_monitor_core and SCALE_DIV near 1000
`timescale 1ns/1ps
module power_monitor_checker
#(
  parameter SCALE_DIV = 1
)
(
  input wire       clock,
  input wire       nrst,
  input wire       byte_valid,
  input wire       read_byte,
  input wire [7:0] read_data,
  input wire       byte_ack,
  input wire       adc_shunt_active,
  input wire       adc_rail_active,
  input wire       alert_out,
  input wire       alert_oe_n
);
  // Longest phase at the bench's divider; a smaller divider needs a larger bound
  localparam int MAX_CT = 340;
  // ==================================================
  // Port relations
  default clocking cb @(posedge clock); endclocking
  property p_reset_idle;
    !nrst |=> read_data == 8'h00 && alert_oe_n && !adc_shunt_active && !adc_rail_active;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
  property p_ack;
    disable iff (!nrst) byte_ack == byte_valid;
  endproperty
  a_ack: assert property (p_ack) else $error("byte not acknowledged");
  property p_od_low;
    disable iff (!nrst) alert_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("alert data not low");
  property p_one_phase;
    disable iff (!nrst) !(adc_shunt_active && adc_rail_active);
  endproperty
  a_one_phase: assert property (p_one_phase) else $error("both phases active");
  property p_read_hold;
    disable iff (!nrst) !read_byte && !$past(read_byte) |=> $stable(read_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
  property p_rail_after_shunt;
    disable iff (!nrst) $rose(adc_rail_active) |-> $past(adc_shunt_active) || $past(adc_shunt_active, 2);
  endproperty
  a_rail_after_shunt: assert property (p_rail_after_shunt) else $error("rail without shunt");
  property p_shunt_ends;
    disable iff (!nrst) $rose(adc_shunt_active) |-> ##[1:MAX_CT] !adc_shunt_active;
  endproperty
  a_shunt_ends: assert property (p_shunt_ends) else $error("shunt phase too long");
  property p_rail_ends;
    disable iff (!nrst) $rose(adc_rail_active) |-> ##[1:MAX_CT] !adc_rail_active;
  endproperty
  a_rail_ends: assert property (p_rail_ends) else $error("rail phase too long");
endmodule
bind power_monitor_core power_monitor_checker #(.SCALE_DIV(SCALE_DIV)) u_checker
(
  .clock(clock), .nrst(nrst), .byte_valid(byte_valid), .read_byte(read_byte),
  .read_data(read_data), .byte_ack(byte_ack), .adc_shunt_active(adc_shunt_active),
  .adc_rail_active(adc_rail_active), .alert_out(alert_out), .alert_oe_n(alert_oe_n)
);

// ==== bench/testbench.sv ====
// Self-checking bench for the monitor core
// Assumes host_port for register traffic; converter samples driven here
`timescale 1ns/1ps
`include "power_monitor_defs.vh"
`define CHK(got, exp) begin n_tests = n_tests + 1; \
  if ((got) !== (exp)) begin fails = fails + 1; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
  // Divider keeps the longest conversion at a few hundred cycles
  localparam SD = 1000;
  reg         clock;
  reg         nrst;
  reg  [15:0] shunt_in;
  reg  [15:0] rail_in;
  reg  [15:0] rd;
  reg  [47:0] tbl [0:7];
  integer     fails;
  integer     n_tests;
  integer     i;
  integer     n;
  wire        frame_start, byte_valid, read_byte, byte_ack;
  wire        shunt_act, rail_act, alert_out, alert_oe_n;
  wire [7:0]  byte_data, read_data;
  wire        alert_pin = alert_oe_n ? 1'b1 : alert_out;
  power_monitor_core #(.SCALE_DIV(SD)) DUT
  (
    .clock(clock), .nrst(nrst), .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data), .read_byte(read_byte), .read_data(read_data),
    .byte_ack(byte_ack), .adc_shunt_sample(shunt_in), .adc_rail_sample(rail_in),
    .adc_shunt_active(shunt_act), .adc_rail_active(rail_act), .alert_in(alert_pin),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n)
  );
  host_port host
  (
    .clock(clock), .read_data(read_data), .frame_start(frame_start),
    .byte_valid(byte_valid), .byte_data(byte_data), .read_byte(read_byte)
  );
  // ==================================================
  // Helpers
  task chk_reg(input [7:0] ptr, input [15:0] exp);
  begin
    host.read_reg(ptr, rd);
    `CHK(rd, exp)
  end
  endtask
  task wait_done;
    integer k;
  begin
    rd = 16'h0000;
    for (k = 0; k < 400 && rd[`SEL_DONE_FLAG] !== 1'b1; k = k + 1)
      host.read_reg(`REG_ALERT_SELECT, rd);
    `CHK(rd[`SEL_DONE_FLAG], 1'b1)
  end
  endtask
  task meas_shunt(input [15:0] setup, input integer exp);
    integer k;
  begin
    host.write_reg(`REG_ADC_SETUP, setup);
    for (k = 0; k < 800 && shunt_act !== 1'b0; k = k + 1) @(negedge clock);
    for (k = 0; k < 800 && shunt_act !== 1'b1; k = k + 1) @(negedge clock);
    for (n = 0; n < 800 && shunt_act === 1'b1; n = n + 1) @(negedge clock);
    `CHK((n >= exp - 1) && (n <= exp + 1), 1'b1)
  end
  endtask
  task tally_and_finish;
  begin
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // ==================================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    fails = fails + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
  // ==================================================
  // Scenarios
  initial
  begin
    fails = 0;
    n_tests = 0;
    nrst = 1'b0;
    shunt_in = 16'h1F40;
    rail_in = 16'h2580;
    tbl[0] = 48'h8000_1000_0001;
    tbl[1] = 48'h4000_1000_0000;
    tbl[2] = 48'hC000_2000_0000;
    tbl[3] = 48'h8000_FFFF_0001;
    tbl[4] = 48'h2000_3000_0000;
    tbl[5] = 48'h1000_3000_0001;
    tbl[6] = 48'h0800_1000_0001;
    tbl[7] = 48'h4000_2000_0001;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    chk_reg(`REG_ADC_SETUP, 16'h4127);
    chk_reg(`REG_CURRENT, 16'h0000);
    chk_reg(`REG_POWER, 16'h0000);
    host.write_reg(`REG_SCALE, 16'h0A00);
    wait_done;
    wait_done;
    chk_reg(`REG_SHUNT_DROP, 16'h1F40);
    chk_reg(`REG_RAIL_LEVEL, 16'h2580);
    chk_reg(`REG_CURRENT, 16'h2710);
    chk_reg(`REG_POWER, 16'h12C0);
    host.write_reg(`REG_CURRENT, 16'h1234);
    chk_reg(`REG_CURRENT, 16'h2710);
    chk_reg(8'h08, 16'h0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      host.write_reg(`REG_ALERT_LIMIT, tbl[i][31:16]);
      host.write_reg(`REG_ALERT_SELECT, tbl[i][47:32]);
      wait_done;
      wait_done;
      `CHK(rd & `SEL_WRITE_MASK, tbl[i][47:32])
      `CHK(rd[`SEL_LIMIT_FLAG], tbl[i][0])
      `CHK(alert_pin, ~tbl[i][0])
    end
    shunt_in = 16'hE0C0;
    wait_done;
    wait_done;
    chk_reg(`REG_CURRENT, 16'hD8F0);
    chk_reg(`REG_POWER, 16'hED40);
    `CHK(alert_pin, 1'b0)
    host.write_reg(`REG_ALERT_SELECT, 16'h0400);
    host.read_reg(`REG_ALERT_SELECT, rd);
    for (n = 0; n < 800 && alert_pin !== 1'b0; n = n + 1) @(negedge clock);
    `CHK(alert_pin, 1'b0)
    host.read_reg(`REG_ALERT_SELECT, rd);
    `CHK(rd[`SEL_DONE_FLAG], 1'b1)
    `CHK(alert_pin, 1'b1)
    wait_done;
    host.write_reg(`REG_ADC_SETUP, 16'h4123);
    // In-flight continuous conversion ends first, then the triggered one
    wait_done;
    wait_done;
    shunt_in = 16'h0100;
    repeat (400) @(negedge clock);
    chk_reg(`REG_SHUNT_DROP, 16'hE0C0);
    host.write_reg(`REG_ADC_SETUP, 16'h4123);
    wait_done;
    chk_reg(`REG_SHUNT_DROP, 16'h0100);
    host.write_reg(`REG_ADC_SETUP, 16'h4120);
    shunt_in = 16'h0200;
    n = 0;
    repeat (400)
    begin
      @(negedge clock);
      n = n + shunt_act + rail_act;
    end
    `CHK(n, 0)
    host.write_reg(`REG_SCALE, 16'h0500);
    chk_reg(`REG_SCALE, 16'h0500);
    chk_reg(`REG_SHUNT_DROP, 16'h0100);
    shunt_in = 16'h0100;
    host.write_reg(`REG_ADC_SETUP, 16'h4327);
    // Alternate samples so only a true mean gives 0x0200
    for (i = 0; i < 3; i = i + 1)
    begin
      @(negedge shunt_act);
      @(negedge clock) shunt_in = 16'h0400 - shunt_in;
    end
    wait_done;
    chk_reg(`REG_SHUNT_DROP, 16'h0200);
    chk_reg(`REG_CURRENT, 16'h0140);
    chk_reg(`REG_POWER, 16'h0099);
    meas_shunt(16'h403F, `CT_US_7 * `CLOCK_MHZ / SD);
    meas_shunt(16'h41C7, `CT_US_0 * `CLOCK_MHZ / SD);
    host.write_reg(`REG_ADC_SETUP, 16'h8000);
    chk_reg(`REG_ADC_SETUP, 16'h4127);
    tally_and_finish;
  end
endmodule

// ==== verilog/conversion_timer.v ====
// Counts one conversion time selected by a three-bit code
// Assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`include "power_monitor_defs.vh"
module conversion_timer
#(
  parameter SCALE_DIV = 1
)
(
  input  wire        clock,
  input  wire        nrst,
  input  wire        start,
  input  wire [2:0]  select,
  output reg         done
);
  // ==================================================
  // Cycle counts; SCALE_DIV shortens them for simulation
  function [31:0] cycles_for;
    input [2:0] code;
    reg   [31:0] us;
    begin
      case (code)
        3'h0:    us = `CT_US_0;
        3'h1:    us = `CT_US_1;
        3'h2:    us = `CT_US_2;
        3'h3:    us = `CT_US_3;
        3'h4:    us = `CT_US_4;
        3'h5:    us = `CT_US_5;
        3'h6:    us = `CT_US_6;
        default: us = `CT_US_7;
      endcase
      cycles_for = (us * `CLOCK_MHZ) / SCALE_DIV;
      if (cycles_for == 32'h0)
        cycles_for = 32'h1;
    end
  endfunction

  reg [31:0] count;
  reg        running;

  always @(posedge clock)
  begin
    done <= 1'b0;
    if (!nrst)
    begin
      count   <= 32'h0;
      running <= 1'b0;
    end
    else if (start)
    begin
      count   <= cycles_for(select);
      running <= 1'b1;
    end
    else if (running)
    begin
      if (count <= 32'h1)
      begin
        running <= 1'b0;
        done    <= 1'b1;
      end
      count <= count - 32'h1;
    end
  end
endmodule

// ==== verilog/power_monitor_core.v ====
// Digital core of a current and power monitor: sequencing, registers, alert
// Assumes a byte-level serial front end delivering start/byte/read strobes
`timescale 1ns/1ps
`include "power_monitor_defs.vh"
// Functional notes
// - Continuous mode converts both, derives current, power
// - Triggered mode converts once per setup write
// - Shutdown stops conversions, registers stay accessible
// - Shutdown held until continuous or triggered chosen
// - Setup holds reset, times, averaging, mode
// - Separate conversion times, 139 us to 8.205 ms
// - Average selected count of samples
// - Sense result is 16-bit signed
// - Current equals sense times scale over 2048
// - Power equals rail times current over 20000
// - Current and power read zero after power-up
// - Alert select and threshold host writable
// - Five limit sources plus conversion ready
// - Only one limit comparison active
// - Crossing drives open-drain alert low
// - Highest enabled limit select bit wins; conversion ready is ORed in
// - Comparisons are signed two's complement
// - Done flag bit 3, limit flag bit 4
// - Write is pointer byte then two data bytes
module power_monitor_core
#(
  parameter SCALE_DIV = 1
)
(
  input  wire        clock,
  input  wire        nrst,
  input  wire        frame_start,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  input  wire        read_byte,
  output reg  [7:0]  read_data,
  output wire        byte_ack,
  input  wire [15:0] adc_shunt_sample,
  input  wire [15:0] adc_rail_sample,
  output wire        adc_shunt_active,
  output wire        adc_rail_active,
  input  wire        alert_in,
  output wire        alert_out,
  output wire        alert_oe_n
);
  // ==================================================
  // Modes and sequencer states
  localparam MODE_SHUTDOWN = 3'h0;
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHUNT = 2'h1;
  localparam ST_RAIL  = 2'h2;
  localparam ST_MATH  = 2'h3;
  reg [15:0] adc_setup;
  reg [15:0] shunt_drop_result;
  reg [15:0] rail_level_result;
  reg [15:0] scale_factor;
  reg [15:0] alert_select;
  reg [15:0] alert_threshold;
  reg        conversion_done_flag;
  reg        limit_hit_flag;
  reg [7:0]  pointer;
  reg [1:0]  byte_index;
  reg [7:0]  high_byte;
  reg [15:0] read_word;
  reg        trigger_pending;
  reg [1:0]  state;
  reg [7:0]  sample_count;
  reg signed [23:0] shunt_acc;
  reg        [23:0] rail_acc;
  wire [15:0] current_result;
  wire [15:0] power_result;
  wire        math_ready;
  wire        timer_done;
  // Unused pin readback; alert level comes from internal state
  reg alert_in_meta;
  reg alert_in_sync;
  // Sample count and divide share one decode; the count is latched at start, the divide follows the current setup
  function [2:0] avg_shift;
    input [2:0] code;
    begin
      case (code)
        3'h0:    avg_shift = 3'h0;
        3'h1:    avg_shift = 3'h2;
        3'h2:    avg_shift = 3'h4;
        3'h3:    avg_shift = 3'h6;
        default: avg_shift = 3'h7;
      endcase
    end
  endfunction

  wire [2:0] mode       = adc_setup[`SETUP_MODE_HI:`SETUP_MODE_LO];
  wire [2:0] avg_code   = adc_setup[`SETUP_AVG_HI:`SETUP_AVG_LO];
  wire       continuous = mode[2];
  wire       triggered  = (mode != MODE_SHUTDOWN) && !mode[2];
  wire       setup_write = byte_valid && (byte_index == 2'h2) && (pointer == `REG_ADC_SETUP);

  // ==================================================
  // Serial register access
  assign byte_ack = byte_valid;

  always @*
  begin
    case (pointer)
      `REG_ADC_SETUP:    read_word = adc_setup;
      `REG_SHUNT_DROP:   read_word = shunt_drop_result;
      `REG_RAIL_LEVEL:   read_word = rail_level_result;
      `REG_POWER:        read_word = power_result;
      `REG_CURRENT:      read_word = current_result;
      `REG_SCALE:        read_word = scale_factor;
      `REG_ALERT_SELECT: read_word = {alert_select[15:5], limit_hit_flag,
                                      conversion_done_flag, alert_select[2:0]};
      `REG_ALERT_LIMIT:  read_word = alert_threshold;
      default:           read_word = 16'h0000;
    endcase
  end

  wire word_write = byte_valid && (byte_index == 2'h2);
  wire soft_reset = word_write && (pointer == `REG_ADC_SETUP)
                    && high_byte[`SETUP_RESET_BIT - 8];
  wire mask_read  = read_byte && (byte_index == 2'h1) && (pointer == `REG_ALERT_SELECT);

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      byte_index <= 2'h0;
      pointer    <= 8'h00;
      high_byte  <= 8'h00;
      read_data  <= 8'h00;
    end
    else
    begin
      if (frame_start)
        byte_index <= 2'h0;
      else if (byte_valid)
      begin
        case (byte_index)
          2'h0:    pointer   <= byte_data;
          2'h1:    high_byte <= byte_data;
          default: ;
        endcase
        byte_index <= (byte_index == 2'h2) ? 2'h1 : byte_index + 2'h1;
      end
      if (read_byte)
      begin
        read_data  <= (byte_index == 2'h1) ? read_word[7:0] : read_word[15:8];
        byte_index <= (byte_index == 2'h1) ? 2'h0 : 2'h1;
      end
    end
  end

  // ==================================================
  // Host-writable registers
  always @(posedge clock)
  begin
    if (!nrst || soft_reset)
    begin
      adc_setup       <= `SETUP_RESET_VALUE;
      scale_factor    <= 16'h0000;
      alert_select    <= 16'h0000;
      alert_threshold <= 16'h0000;
    end
    else if (word_write)
    begin
      case (pointer)
        `REG_ADC_SETUP:    adc_setup <= {1'b0, high_byte[6:0], byte_data};
        `REG_SCALE:        scale_factor <= {high_byte, byte_data};
        `REG_ALERT_SELECT: alert_select <= {high_byte, byte_data} & `SEL_WRITE_MASK;
        `REG_ALERT_LIMIT:  alert_threshold <= {high_byte, byte_data};
        default: ;
      endcase
    end
  end

  // ==================================================
  // Conversion sequencer
  wire timer_start = (state == ST_IDLE && (continuous || trigger_pending)) ||
                     (state == ST_SHUNT && timer_done) ||
                     (state == ST_RAIL && timer_done && sample_count != 8'h01);
  wire [2:0] timer_select = (state == ST_IDLE || state == ST_RAIL)
                            ? adc_setup[`SETUP_SHUNT_CT_HI:`SETUP_SHUNT_CT_LO]
                            : adc_setup[`SETUP_RAIL_CT_HI:`SETUP_RAIL_CT_LO];

  conversion_timer
  #(
    .SCALE_DIV (SCALE_DIV)
  )
  u_timer
  (
    .clock  (clock),
    .nrst   (nrst),
    .start  (timer_start),
    .select (timer_select),
    .done   (timer_done)
  );

  assign adc_shunt_active = (state == ST_SHUNT);
  assign adc_rail_active  = (state == ST_RAIL);

  wire [2:0]  shift    = avg_shift(avg_code);
  wire signed [23:0] shunt_mean = shunt_acc >>> shift;
  wire        [23:0] rail_mean  = rail_acc >> shift;

  always @(posedge clock)
  begin
    if (!nrst || soft_reset)
    begin
      state             <= ST_IDLE;
      sample_count      <= 8'h00;
      shunt_acc         <= 24'h000000;
      rail_acc          <= 24'h000000;
      shunt_drop_result <= 16'h0000;
      rail_level_result <= 16'h0000;
      trigger_pending   <= 1'b0;
    end
    else
    begin
      if (setup_write && high_byte[7] == 1'b0 && byte_data[2:0] != MODE_SHUTDOWN
          && byte_data[2] == 1'b0)
        trigger_pending <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (continuous || trigger_pending)
          begin
            state           <= ST_SHUNT;
            sample_count    <= 8'h01 << shift;
            shunt_acc       <= 24'h000000;
            rail_acc        <= 24'h000000;
            trigger_pending <= 1'b0;
          end
        end
        ST_SHUNT:
        begin
          if (timer_done)
          begin
            shunt_acc <= shunt_acc + {{8{adc_shunt_sample[15]}}, adc_shunt_sample};
            state     <= ST_RAIL;
          end
        end
        ST_RAIL:
        begin
          if (timer_done)
          begin
            rail_acc <= rail_acc + {8'h00, adc_rail_sample};
            if (sample_count == 8'h01)
              state <= ST_MATH;
            else
            begin
              sample_count <= sample_count - 8'h01;
              state        <= ST_SHUNT;
            end
          end
        end
        ST_MATH:
        begin
          shunt_drop_result <= shunt_mean[15:0];
          rail_level_result <= rail_mean[15:0];
          state             <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (!continuous && !triggered && state != ST_MATH)
        state <= ST_IDLE;
    end
  end

  // ==================================================
  // Derived current and power, zero until first update
  reg math_go;
  always @(posedge clock)
  begin
    if (!nrst)
      math_go <= 1'b0;
    else
      math_go <= (state == ST_MATH);
  end

  result_math u_math
  (
    .clock      (clock),
    .nrst       (nrst && !soft_reset),
    .go         (math_go),
    .shunt_drop (shunt_drop_result),
    .rail_level (rail_level_result),
    .scale      (scale_factor),
    .current    (current_result),
    .power      (power_result),
    .ready      (math_ready)
  );

  // ==================================================
  // Alert comparison; single source by priority
  reg        cmp_hit;
  always @*
  begin
    if (alert_select[`SEL_SHUNT_OVER])
      cmp_hit = $signed(shunt_drop_result) > $signed(alert_threshold);
    else if (alert_select[`SEL_SHUNT_UNDER])
      cmp_hit = $signed(shunt_drop_result) < $signed(alert_threshold);
    else if (alert_select[`SEL_RAIL_OVER])
      cmp_hit = $signed(rail_level_result) > $signed(alert_threshold);
    else if (alert_select[`SEL_RAIL_UNDER])
      cmp_hit = $signed(rail_level_result) < $signed(alert_threshold);
    else if (alert_select[`SEL_POWER_OVER])
      cmp_hit = $signed(power_result) > $signed(alert_threshold);
    else
      cmp_hit = 1'b0;
  end

  // Flags: set wins over the read-clear of the select register
  always @(posedge clock)
  begin
    if (!nrst || soft_reset)
    begin
      conversion_done_flag <= 1'b0;
      limit_hit_flag       <= 1'b0;
      alert_in_meta        <= 1'b1;
      alert_in_sync        <= 1'b1;
    end
    else
    begin
      alert_in_meta <= alert_in;
      alert_in_sync <= alert_in_meta;
      if (math_ready)
        conversion_done_flag <= 1'b1;
      else if (mask_read)
        conversion_done_flag <= 1'b0;
      limit_hit_flag <= cmp_hit;
    end
  end

  wire alert_active = limit_hit_flag ||
                      (alert_select[`SEL_CONV_READY] && conversion_done_flag);
  assign alert_out  = 1'b0;
  assign alert_oe_n = !alert_active;
endmodule

// ==== verilog/power_monitor_defs.vh ====
// Register offsets, field positions, reset values and timing counts
// Assumes a 40 MHz system clock
`ifndef POWER_MONITOR_DEFS_VH
`define POWER_MONITOR_DEFS_VH
// ==================================================
// Register pointers
`define REG_ADC_SETUP     8'h00
`define REG_SHUNT_DROP    8'h01
`define REG_RAIL_LEVEL    8'h02
`define REG_POWER         8'h03
`define REG_CURRENT       8'h04
`define REG_SCALE         8'h05
`define REG_ALERT_SELECT  8'h06
`define REG_ALERT_LIMIT   8'h07
// ==================================================
// Setup register fields
`define SETUP_RESET_BIT   15
`define SETUP_AVG_HI      11
`define SETUP_AVG_LO      9
`define SETUP_RAIL_CT_HI  8
`define SETUP_RAIL_CT_LO  6
`define SETUP_SHUNT_CT_HI 5
`define SETUP_SHUNT_CT_LO 3
`define SETUP_MODE_HI     2
`define SETUP_MODE_LO     0
`define SETUP_RESET_VALUE 16'h4127
// ==================================================
// Alert select fields
`define SEL_SHUNT_OVER    15
`define SEL_SHUNT_UNDER   14
`define SEL_RAIL_OVER     13
`define SEL_RAIL_UNDER    12
`define SEL_POWER_OVER    11
`define SEL_CONV_READY    10
`define SEL_LIMIT_FLAG    4
`define SEL_DONE_FLAG     3
`define SEL_WRITE_MASK    16'hFC00
// ==================================================
// Arithmetic constants
`define CURRENT_SHIFT     11
`define POWER_DIVISOR     32'd20000
// ==================================================
// Conversion times, microseconds per setting
`define CLOCK_MHZ         40
`define CT_US_0           139
`define CT_US_1           203
`define CT_US_2           269
`define CT_US_3           525
`define CT_US_4           1037
`define CT_US_5           2061
`define CT_US_6           4109
`define CT_US_7           8205
`endif

// ==== verilog/result_math.v ====
// Current and power arithmetic from raw readings
// Assumes inputs hold steady for the two cycles after go
`timescale 1ns/1ps
`include "power_monitor_defs.vh"
module result_math
(
  input  wire        clock,
  input  wire        nrst,
  input  wire        go,
  input  wire [15:0] shunt_drop,
  input  wire [15:0] rail_level,
  input  wire [15:0] scale,
  output reg  [15:0] current,
  output reg  [15:0] power,
  output reg         ready
);
  // ==================================================
  // Current first, power one cycle later from the new current
  wire signed [32:0] cur_product = $signed(shunt_drop) * $signed({1'b0, scale});
  wire signed [32:0] cur_div     = cur_product >>> `CURRENT_SHIFT;
  wire signed [32:0] pwr_product = $signed({1'b0, rail_level}) * $signed(current);
  wire signed [32:0] pwr_div     = pwr_product / $signed({1'b0, `POWER_DIVISOR});
  reg                stage;

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      current <= 16'h0000;
      power   <= 16'h0000;
      ready   <= 1'b0;
      stage   <= 1'b0;
    end
    else
    begin
      ready <= 1'b0;
      stage <= go;
      if (go)
        current <= cur_div[15:0];
      if (stage)
      begin
        power <= pwr_div[15:0];
        ready <= 1'b1;
      end
    end
  end
endmodule
